// file: acpc_divider.sv
`timescale 1ns/1ps
module acpc_divider
   import acpc_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [1:0] ratio,
   input wire logic sync,
   input wire logic [2:0] sync_state,
   output logic div_clk
);
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   logic [2:0] mask;

   always_comb
   begin
      unique case (ratio)
         DIV_BY1: mask = 3'h0;
         DIV_BY2: mask = 3'h1;
         DIV_BY4: mask = 3'h3;
         DIV_BY8: mask = DIV_MAX_CNT;
      endcase
      if (sync)
         next_cnt = sync_state & mask;
      else
         next_cnt = (cnt + 3'h1) & mask;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         cnt <= 3'h0;
      else if (ce)
         cnt <= next_cnt;
   end

   // Top bit of a power-of-two counter gives equal high and low halves
   always_comb
   begin
      unique case (ratio)
         DIV_BY1: div_clk = clk;
         DIV_BY2: div_clk = cnt[0];
         DIV_BY4: div_clk = cnt[1];
         DIV_BY8: div_clk = cnt[2];
      endcase
   end

   a_div_wrap: assert property (@(posedge clk) disable iff (!nrst)
      ce && !sync && ratio == DIV_BY2 && $stable(ratio) |=> cnt[0] != $past(cnt[0]))
      else $error("divide by two did not toggle");
   a_sync_load: assert property (@(posedge clk) disable iff (!nrst)
      ce && sync |=> cnt == ($past(sync_state) & $past(mask)))
      else $error("sysref did not load divider state");
   c_sync: cover property (@(posedge clk) disable iff (!nrst) ce && sync && ratio == DIV_BY8);
endmodule

// file: acpc_pkg.sv
// Summary of operation
// - Divide sample clock by 1, 2, 4, 8
// - Divider accepts clocks up to 4 GHz limit
// - Valid sysref resets divider to programmed state
// - Divide by two gives 50% duty
// - Per-channel half-cycle delay, link stays stable
// - Fine delay enable bit 0, 8-bit value
// - Fine value maps to edge shift range
// - Fine delay enable resets sample datapath
// - Fine value rewrite keeps link stable
// - Reference register selects internal or external
// - Full-scale adjust works with either reference
// - High pin enters low power, default power-down
// - Power-down stops link, also via registers
// - Standby sends zeros, or K when bit7
// - Diode enable bit 0, channel A selected
// - Pin A outputs diode voltage when selected
package acpc_pkg;
   localparam logic [11:0] ADDR_CHAN_INDEX = 12'h008;
   localparam logic [11:0] ADDR_REF_SEL = 12'h024;
   localparam logic [11:0] ADDR_FS_ADJ = 12'h025;
   localparam logic [11:0] ADDR_TEMP_DIODE = 12'h028;
   localparam logic [11:0] ADDR_FULL_POWER_DOWN_STATE_CTRL = 12'h03F;
   localparam logic [11:0] ADDR_PIN_FUNC = 12'h040;
   localparam logic [11:0] ADDR_CLK_DIV = 12'h10B;
   localparam logic [11:0] ADDR_HALF_DLY = 12'h10C;
   localparam logic [11:0] ADDR_FINE_EN = 12'h117;
   localparam logic [11:0] ADDR_FINE_VAL = 12'h118;
   localparam logic [11:0] ADDR_FILL_CTRL = 12'h571;
   localparam int NUM_CHAN = 2;
   localparam logic [7:0] CHAN_ALL = 8'h03;
   localparam logic [7:0] REG_ZERO = 8'h00;
   localparam int FINE_EN_BIT = 0;
   localparam int HALF_EN_BIT = 0;
   localparam int DIODE_EN_BIT = 0;
   localparam int REF_EXT_BIT = 0;
   localparam int FILL_K_BIT = 7;
   localparam int PD_STBY_BIT = 0;
   localparam int PD_FORCE_BIT = 1;
   localparam logic [2:0] PIN_FUNC_DIODE = 3'h7;
   localparam logic [1:0] DIV_BY1 = 2'h0;
   localparam logic [1:0] DIV_BY2 = 2'h1;
   localparam logic [1:0] DIV_BY4 = 2'h2;
   localparam logic [1:0] DIV_BY8 = 2'h3;
   localparam logic [2:0] DIV_MAX_CNT = 3'h7;
   localparam int CHAN_A = 0;

   typedef enum logic [1:0] {ACPC_RUN = 2'b00, ACPC_STBY = 2'b01, ACPC_FULL_POWER_DOWN_STATE = 2'b11} acpc_pwr_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [7:0] wdata;
   } acpc_req_s;

   typedef struct packed {
      logic [NUM_CHAN-1:0] fine_en;
      logic [NUM_CHAN*8-1:0] fine_val;
      logic [NUM_CHAN-1:0] half_dly;
      logic ext_ref;
      logic [7:0] fs_adj;
   } acpc_cfg_s;
endpackage

// file: acpc_source.sv
`timescale 1ns/1ps
module acpc_source
   import acpc_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic fire,
   output logic sysref,
   output logic [15:0] core_sample
);
   import acpc_pkg::*;
   logic [14:0] count;
   // Sample source: top bit set so a passed sample is never zero
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         count <= 15'h0000;
         sysref <= 1'h0;
         core_sample <= 16'h8000;
      end
      else
      begin
         count <= count + 15'h0001;
         sysref <= fire;
         core_sample <= {1'h1, count};
      end
   end
endmodule

// file: acpc_top.sv
`timescale 1ns/1ps
module acpc_top
   import acpc_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input acpc_pkg::acpc_req_s req,
   input wire logic sysref,
   input wire logic power_down_standby_pin,
   input wire logic [15:0] core_sample,
   output logic [7:0] rdata,
   output logic div_clk_out,
   output acpc_pkg::acpc_cfg_s cfg,
   output logic datapath_reset,
   output logic link_enable,
   output logic link_send_k,
   output logic [15:0] link_sample,
   output logic diode_enable,
   output logic threshold_indicator_pin_a_diode,
   output logic [2:0] sysref_state
);
   import acpc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Register state
   logic [7:0] chan_index, ref_sel, fs_adj, diode_ctrl, pd_ctrl, pin_func, clk_div, fill_ctrl;
   logic [7:0] next_chan_index, next_ref_sel, next_fs_adj, next_diode_ctrl;
   logic [7:0] next_pd_ctrl, next_pin_func, next_clk_div, next_fill_ctrl;
   logic [7:0] half_dly [NUM_CHAN];
   logic [7:0] fine_en [NUM_CHAN];
   logic [7:0] fine_val [NUM_CHAN];
   logic [7:0] next_half_dly [NUM_CHAN];
   logic [7:0] next_fine_en [NUM_CHAN];
   logic [7:0] next_fine_val [NUM_CHAN];
   logic [NUM_CHAN-1:0] fine_rise;
   logic [7:0] next_rdata;
   logic wr_ok;

   assign wr_ok = req.wr && ce;

   // Global registers
   always_comb
   begin
      next_chan_index = chan_index;
      next_ref_sel = ref_sel;
      next_fs_adj = fs_adj;
      next_pd_ctrl = pd_ctrl;
      next_pin_func = pin_func;
      next_clk_div = clk_div;
      next_fill_ctrl = fill_ctrl;
      next_diode_ctrl = diode_ctrl;
      if (req.wr)
      begin
         unique case (req.addr)
            ADDR_CHAN_INDEX: next_chan_index = req.wdata;
            ADDR_REF_SEL: next_ref_sel = req.wdata;
            ADDR_FS_ADJ: next_fs_adj = req.wdata;
            ADDR_FULL_POWER_DOWN_STATE_CTRL: next_pd_ctrl = req.wdata;
            ADDR_PIN_FUNC: next_pin_func = req.wdata;
            ADDR_CLK_DIV: next_clk_div = req.wdata;
            ADDR_FILL_CTRL: next_fill_ctrl = req.wdata;
            ADDR_TEMP_DIODE:
            begin
               if (chan_index[CHAN_A])
                  next_diode_ctrl = req.wdata;
            end
            default: next_chan_index = chan_index;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         chan_index <= CHAN_ALL;
         ref_sel <= REG_ZERO;
         fs_adj <= REG_ZERO;
         pd_ctrl <= REG_ZERO;
         pin_func <= REG_ZERO;
         clk_div <= REG_ZERO;
         fill_ctrl <= REG_ZERO;
         diode_ctrl <= REG_ZERO;
      end
      else if (ce)
      begin
         chan_index <= next_chan_index;
         ref_sel <= next_ref_sel;
         fs_adj <= next_fs_adj;
         pd_ctrl <= next_pd_ctrl;
         pin_func <= next_pin_func;
         clk_div <= next_clk_div;
         fill_ctrl <= next_fill_ctrl;
         diode_ctrl <= next_diode_ctrl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-channel registers
   genvar g;
   generate
      for (g = 0; g < NUM_CHAN; g++)
      begin : gen_chan
         logic sel;
         assign sel = req.wr && chan_index[g];
         always_comb
         begin
            next_half_dly[g] = half_dly[g];
            next_fine_en[g] = fine_en[g];
            next_fine_val[g] = fine_val[g];
            if (sel && req.addr == ADDR_HALF_DLY)
               next_half_dly[g] = req.wdata;
            if (sel && req.addr == ADDR_FINE_EN)
               next_fine_en[g] = req.wdata;
            if (sel && req.addr == ADDR_FINE_VAL)
               next_fine_val[g] = req.wdata;
         end
         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
            begin
               half_dly[g] <= REG_ZERO;
               fine_en[g] <= REG_ZERO;
               fine_val[g] <= REG_ZERO;
            end
            else if (ce)
            begin
               half_dly[g] <= next_half_dly[g];
               fine_en[g] <= next_fine_en[g];
               fine_val[g] <= next_fine_val[g];
            end
         end
         assign fine_rise[g] = next_fine_en[g][FINE_EN_BIT] && !fine_en[g][FINE_EN_BIT];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Clock divider
   logic div_clk;
   logic sysref_q;
   logic next_sysref_q;
   logic sync_pulse;

   assign next_sysref_q = sysref;
   assign sync_pulse = sysref && !sysref_q;

   acpc_divider u_div (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .ratio(clk_div[1:0]),
      .sync(sync_pulse),
      .sync_state(clk_div[6:4]),
      .div_clk(div_clk)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Power mode
   acpc_pwr_e pwr;
   acpc_pwr_e next_pwr;

   always_comb
   begin
      next_pwr = ACPC_RUN;
      if (power_down_standby_pin || pd_ctrl[PD_FORCE_BIT])
      begin
         if (pd_ctrl[PD_STBY_BIT])
            next_pwr = ACPC_STBY;
         else
            next_pwr = ACPC_FULL_POWER_DOWN_STATE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Output registers
   acpc_cfg_s next_cfg;
   logic [15:0] next_link_sample;

   always_comb
   begin
      next_cfg.ext_ref = ref_sel[REF_EXT_BIT];
      next_cfg.fs_adj = fs_adj;
      for (int i = 0; i < NUM_CHAN; i++)
      begin
         next_cfg.fine_en[i] = fine_en[i][FINE_EN_BIT];
         next_cfg.fine_val[i*8 +: 8] = fine_val[i];
         next_cfg.half_dly[i] = half_dly[i][HALF_EN_BIT];
      end
      next_link_sample = (pwr == ACPC_RUN) ? core_sample : 16'h0000;
      next_rdata = REG_ZERO;
      if (req.rd)
      begin
         unique case (req.addr)
            ADDR_CHAN_INDEX: next_rdata = chan_index;
            ADDR_REF_SEL: next_rdata = ref_sel;
            ADDR_FS_ADJ: next_rdata = fs_adj;
            ADDR_TEMP_DIODE: next_rdata = diode_ctrl;
            ADDR_FULL_POWER_DOWN_STATE_CTRL: next_rdata = pd_ctrl;
            ADDR_PIN_FUNC: next_rdata = pin_func;
            ADDR_CLK_DIV: next_rdata = clk_div;
            ADDR_FILL_CTRL: next_rdata = fill_ctrl;
            ADDR_HALF_DLY: next_rdata = chan_index[CHAN_A] ? half_dly[0] : half_dly[1];
            ADDR_FINE_EN: next_rdata = chan_index[CHAN_A] ? fine_en[0] : fine_en[1];
            ADDR_FINE_VAL: next_rdata = chan_index[CHAN_A] ? fine_val[0] : fine_val[1];
            default: next_rdata = REG_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pwr <= ACPC_RUN;
         sysref_q <= 1'b0;
         rdata <= REG_ZERO;
         div_clk_out <= 1'b0;
         cfg <= '0;
         datapath_reset <= 1'b0;
         link_enable <= 1'b0;
         link_send_k <= 1'b0;
         link_sample <= 16'h0000;
         diode_enable <= 1'b0;
         threshold_indicator_pin_a_diode <= 1'b0;
         sysref_state <= 3'h0;
      end
      else if (ce)
      begin
         pwr <= next_pwr;
         sysref_q <= next_sysref_q;
         rdata <= next_rdata;
         div_clk_out <= div_clk;
         cfg <= next_cfg;
         datapath_reset <= |fine_rise;
         link_enable <= next_pwr != ACPC_FULL_POWER_DOWN_STATE;
         link_send_k <= next_pwr == ACPC_STBY && fill_ctrl[FILL_K_BIT];
         link_sample <= next_link_sample;
         diode_enable <= diode_ctrl[DIODE_EN_BIT];
         threshold_indicator_pin_a_diode <= diode_ctrl[DIODE_EN_BIT] && pin_func[2:0] == PIN_FUNC_DIODE;
         sysref_state <= clk_div[6:4];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   a_fine_reset: assert property (@(posedge clk) disable iff (!nrst)
      ce && wr_ok && req.addr == ADDR_FINE_EN && req.wdata[FINE_EN_BIT] && chan_index[CHAN_A]
      && !fine_en[0][FINE_EN_BIT] |=> datapath_reset)
      else $error("fine delay enable gave no datapath reset");
   a_full_power_down_state_link: assert property (@(posedge clk) disable iff (!nrst)
      ce && power_down_standby_pin && !pd_ctrl[PD_STBY_BIT] |=> !link_enable)
      else $error("link kept running in power-down");
   a_stby_zero: assert property (@(posedge clk) disable iff (!nrst)
      ce && pwr == ACPC_STBY && next_pwr == ACPC_STBY |=> link_sample == 16'h0000 && link_enable)
      else $error("standby did not send zero samples");
   a_diode_chan: assert property (@(posedge clk) disable iff (!nrst)
      ce && wr_ok && req.addr == ADDR_TEMP_DIODE && !chan_index[CHAN_A] |=> $stable(diode_ctrl))
      else $error("diode written without channel A");
   a_chan_sel: assert property (@(posedge clk) disable iff (!nrst)
      wr_ok && req.addr == ADDR_FINE_VAL && !chan_index[1] |=> $stable(fine_val[1]))
      else $error("unselected channel was written");
   a_fine_keep: assert property (@(posedge clk) disable iff (!nrst)
      wr_ok && req.addr == ADDR_FINE_VAL |=> !datapath_reset)
      else $error("fine value write reset datapath");
   a_link_k: assert property (@(posedge clk) disable iff (!nrst)
      ce && next_pwr == ACPC_STBY && fill_ctrl[FILL_K_BIT] |=> link_send_k)
      else $error("standby fill did not select K characters");
   a_run_pass: assert property (@(posedge clk) disable iff (!nrst)
      ce && nrst && pwr == ACPC_RUN |=> link_sample == $past(core_sample))
      else $error("run mode did not pass samples");
   a_run_link: assert property (@(posedge clk) disable iff (!nrst)
      ce && nrst && !power_down_standby_pin && !pd_ctrl[PD_FORCE_BIT] |=> link_enable && !link_send_k)
      else $error("link not running at full power");
   a_full_power_down_state_force: assert property (@(posedge clk) disable iff (!nrst)
      ce && pd_ctrl[PD_FORCE_BIT] && !pd_ctrl[PD_STBY_BIT] |=> !link_enable)
      else $error("register power-down kept link running");
   a_pin_diode: assert property (@(posedge clk) disable iff (!nrst)
      ce && diode_ctrl[DIODE_EN_BIT] && pin_func[2:0] == PIN_FUNC_DIODE |=> threshold_indicator_pin_a_diode)
      else $error("pin A did not carry diode output");
   a_diode_out: assert property (@(posedge clk) disable iff (!nrst)
      ce |=> diode_enable == $past(diode_ctrl[DIODE_EN_BIT]))
      else $error("diode enable did not follow its register");
   a_ref_sel: assert property (@(posedge clk) disable iff (!nrst)
      ce |=> cfg.ext_ref == $past(ref_sel[REF_EXT_BIT]))
      else $error("reference select did not follow its register");
   a_fs_write: assert property (@(posedge clk) disable iff (!nrst)
      wr_ok && req.addr == ADDR_FS_ADJ |=> fs_adj == $past(req.wdata))
      else $error("full-scale write did not land");
   a_half_keep: assert property (@(posedge clk) disable iff (!nrst)
      wr_ok && req.addr == ADDR_HALF_DLY |=> !datapath_reset)
      else $error("half delay write reset datapath");
   a_half_chan: assert property (@(posedge clk) disable iff (!nrst)
      wr_ok && req.addr == ADDR_HALF_DLY && !chan_index[CHAN_A] |=> $stable(half_dly[CHAN_A]))
      else $error("unselected channel half delay was written");
   a_sysref_state: assert property (@(posedge clk) disable iff (!nrst)
      ce |=> sysref_state == $past(clk_div[6:4]))
      else $error("sysref state did not follow its field");

   c_stby: cover property (@(posedge clk) disable iff (!nrst) pwr == ACPC_STBY && link_send_k);
   c_diode: cover property (@(posedge clk) disable iff (!nrst) threshold_indicator_pin_a_diode);
   c_full_power_down_state: cover property (@(posedge clk) disable iff (!nrst) pwr == ACPC_FULL_POWER_DOWN_STATE);
   c_fine: cover property (@(posedge clk) disable iff (!nrst) datapath_reset);
endmodule

// file: adc_clock_power_control_tb.sv
`timescale 1ns/1ps
module adc_clock_power_control_tb;
   import acpc_pkg::*;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic ce = 1'h1;
   logic fire = 1'h0;
   logic pin = 1'h0;
   acpc_req_s req = '0;
   logic sysref;
   logic [15:0] core_sample;
   logic [7:0] rdata;
   logic div_clk_out;
   acpc_cfg_s cfg;
   logic datapath_reset;
   logic link_enable;
   logic link_send_k;
   logic [15:0] link_sample;
   logic diode_enable;
   logic pin_a_diode;
   logic [2:0] sysref_state;
   int fails = 0;
   int tests_run = 0;
   int pulses = 0;
   int d1;
   int d2;
   int d3;
   int hi;
   int lo;
   localparam logic [11:0] ADDRS [11] = '{ADDR_CHAN_INDEX, ADDR_REF_SEL, ADDR_FS_ADJ, ADDR_TEMP_DIODE,
      ADDR_FULL_POWER_DOWN_STATE_CTRL, ADDR_PIN_FUNC, ADDR_CLK_DIV, ADDR_HALF_DLY, ADDR_FINE_EN, ADDR_FINE_VAL, ADDR_FILL_CTRL};

   always #10 clk = ~clk;
   always @(posedge clk)
      if (datapath_reset === 1'h1)
         pulses <= pulses + 1;

   acpc_source src_u (.clk(clk), .nrst(nrst), .fire(fire), .sysref(sysref), .core_sample(core_sample));
   acpc_top dut_u (.clk(clk), .nrst(nrst), .ce(ce), .req(req), .sysref(sysref),
      .power_down_standby_pin(pin), .core_sample(core_sample), .rdata(rdata), .div_clk_out(div_clk_out),
      .cfg(cfg), .datapath_reset(datapath_reset), .link_enable(link_enable), .link_send_k(link_send_k),
      .link_sample(link_sample), .diode_enable(diode_enable), .threshold_indicator_pin_a_diode(pin_a_diode),
      .sysref_state(sysref_state));

   ////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (fails == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
      #1;
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clk);
      req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
      @(posedge clk);
      req <= '0;
      #1;
      chk("read data", {8'h00, exp}, {8'h00, rdata});
   endtask

   task automatic until_level(input logic lvl, output int n);
      n = 0;
      while (div_clk_out !== lvl && n < 40)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 40)
      begin
         fails++;
         $display("[FAIL] divider wait expected edge seen none");
         conclude();
      end
   endtask

   task automatic sync_delay(output int d);
      int n0;
      int n1;
      @(posedge clk);
      fire <= 1'h1;
      @(posedge clk);
      fire <= 1'h0;
      repeat (2) @(posedge clk);
      #1;
      until_level(1'h0, n0);
      until_level(1'h1, n1);
      d = n0 + n1;
   endtask

   task automatic set_pin(input logic v);
      @(posedge clk);
      pin <= v;
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic pwr_chk(input logic en, input logic k, input logic run);
      @(posedge clk);
      #1;
      chk("link enable", 16'(en), 16'(link_enable));
      chk("send k", 16'(k), 16'(link_send_k));
      chk("sample passed", 16'(run), 16'(link_sample != 16'h0000));
   endtask

   ////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      #1;
      foreach (ADDRS[i])
         rd(ADDRS[i], (ADDRS[i] == ADDR_CHAN_INDEX) ? CHAN_ALL : REG_ZERO);
      wr(12'h7FF, 8'h5A);
      rd(12'h7FF, 8'h00);
      pwr_chk(1'h1, 1'h0, 1'h1);
      // Divider ratios and duty
      for (int r = 1; r < 4; r++)
      begin
         wr(ADDR_CLK_DIV, 8'(r));
         until_level(1'h0, hi);
         until_level(1'h1, lo);
         until_level(1'h0, hi);
         until_level(1'h1, lo);
         chk("divider high", 16'(1 << (r - 1)), 16'(hi));
         chk("divider low", 16'(1 << (r - 1)), 16'(lo));
      end
      // Sysref alignment
      wr(ADDR_CLK_DIV, 8'h53);
      chk("sysref state", 16'h0005, {13'h0000, sysref_state});
      sync_delay(d1);
      repeat (3) @(posedge clk);
      sync_delay(d2);
      chk("sysref repeat phase", 16'(d1), 16'(d2));
      wr(ADDR_CLK_DIV, 8'h13);
      sync_delay(d3);
      chk("sysref state phase", 16'h0001, 16'(d1 != d3));
      // Fine delay per channel
      wr(ADDR_CHAN_INDEX, 8'h01);
      pulses = 0;
      wr(ADDR_FINE_EN, 8'h01);
      repeat (2) @(posedge clk);
      #1;
      chk("datapath reset pulses", 16'h0001, 16'(pulses));
      chk("fine enable", 16'h0001, 16'(cfg.fine_en));
      wr(ADDR_FINE_VAL, 8'hA7);
      wr(ADDR_FINE_EN, 8'h01);
      chk("datapath reset pulses", 16'h0001, 16'(pulses));
      chk("fine value", 16'h00A7, cfg.fine_val);
      chk("link stable", 16'h0001, 16'(link_enable));
      wr(ADDR_CHAN_INDEX, 8'h02);
      wr(ADDR_FINE_VAL, 8'h3C);
      wr(ADDR_FINE_EN, 8'h01);
      repeat (2) @(posedge clk);
      #1;
      chk("fine value", 16'h3CA7, cfg.fine_val);
      chk("datapath reset pulses", 16'h0002, 16'(pulses));
      rd(ADDR_FINE_VAL, 8'h3C);
      // Half-cycle delay
      wr(ADDR_HALF_DLY, 8'h01);
      chk("half delay", 16'h0002, 16'(cfg.half_dly));
      chk("datapath reset pulses", 16'h0002, 16'(pulses));
      chk("link stable", 16'h0001, 16'(link_enable));
      // Reference and full scale
      wr(ADDR_REF_SEL, 8'h01);
      wr(ADDR_FS_ADJ, 8'h5A);
      chk("external ref", 16'h0001, 16'(cfg.ext_ref));
      chk("full scale", 16'h005A, 16'(cfg.fs_adj));
      wr(ADDR_REF_SEL, 8'h00);
      chk("external ref", 16'h0000, 16'(cfg.ext_ref));
      chk("full scale", 16'h005A, 16'(cfg.fs_adj));
      rd(ADDR_FS_ADJ, 8'h5A);
      @(posedge clk);
      ce <= 1'h0;
      wr(ADDR_FS_ADJ, 8'h33);
      @(posedge clk);
      ce <= 1'h1;
      rd(ADDR_FS_ADJ, 8'h5A);
      // Temperature diode
      wr(ADDR_TEMP_DIODE, 8'h01);
      chk("diode refused", 16'h0000, 16'(diode_enable));
      wr(ADDR_CHAN_INDEX, 8'h01);
      wr(ADDR_TEMP_DIODE, 8'h01);
      chk("diode enable", 16'h0001, 16'(diode_enable));
      wr(ADDR_PIN_FUNC, {5'h00, PIN_FUNC_DIODE});
      chk("pin diode", 16'h0001, 16'(pin_a_diode));
      wr(ADDR_PIN_FUNC, 8'h06);
      chk("pin diode", 16'h0000, 16'(pin_a_diode));
      // Power modes
      set_pin(1'h1);
      pwr_chk(1'h0, 1'h0, 1'h0);
      wr(ADDR_FULL_POWER_DOWN_STATE_CTRL, 8'h01);
      pwr_chk(1'h1, 1'h0, 1'h0);
      wr(ADDR_FILL_CTRL, 8'h80);
      pwr_chk(1'h1, 1'h1, 1'h0);
      set_pin(1'h0);
      pwr_chk(1'h1, 1'h0, 1'h1);
      wr(ADDR_FULL_POWER_DOWN_STATE_CTRL, 8'h02);
      pwr_chk(1'h0, 1'h0, 1'h0);
      wr(ADDR_FULL_POWER_DOWN_STATE_CTRL, 8'h03);
      pwr_chk(1'h1, 1'h1, 1'h0);
      wr(ADDR_FULL_POWER_DOWN_STATE_CTRL, 8'h00);
      pwr_chk(1'h1, 1'h0, 1'h1);
      conclude();
   end
endmodule
